// ### inc/cqd_consts.svh
// Purpose: shared numeric constants of the coefficient quantizer datapath
// Assumes: quantizer parameter is carried in its offset form, 0 to 51
// Notes: definitions only
`ifndef CQD_CONSTS_SVH
`define CQD_CONSTS_SVH

`define CQD_QP_PERIOD 6
`define CQD_QP_MAX 6'h33
`define CQD_SHIFT_AC 15
`define CQD_SHIFT_DC 16
`define CQD_ROUND_EXP 13
`define CQD_EXP_LUMA_DC 4
`define CQD_EXP_CHROMA_DC 3
`define CQD_NORM_ADD 17'h0_0020
`define CQD_NORM_SHIFT 6
`define CQD_LEVEL_MAX 32'h0000_7FFF
`define CQD_LUMA_DC_LAST 4'hF
`define CQD_CHROMA_DC_LAST 4'h3
`define CQD_CHROMA_AC_RUN_MAX 4'hE
`define CQD_POS_DC 4'h0

`endif

// ### inc/cqd_pkg.sv
// Purpose: types shared by the coefficient quantizer datapath
// Assumes: one coefficient per accepted handshake
// Notes: position is row in bits 3:2, column in bits 1:0
package cqd_pkg;
  typedef enum logic [1:0] {CQD_OP_QUANT, CQD_OP_DEQUANT, CQD_OP_DC_DEQUANT,
                            CQD_OP_NORM} cqd_op_t;
  typedef enum logic [1:0] {CQD_BLK_AC4, CQD_BLK_LUMA_DC, CQD_BLK_CHROMA_DC} cqd_blk_t;
  typedef struct packed {
    cqd_op_t op;
    cqd_blk_t blk;
    logic chroma_ac;
    logic [5:0] quantizer_parameter;
    logic [1:0] rnd_shift;
    logic [3:0] pos;
    logic last;
    logic signed [15:0] data;
  } cqd_coef_in_t;
  typedef struct packed {
    logic signed [15:0] data;
    logic [3:0] pos;
    logic last;
    logic ev_level;
    logic [3:0] run;
    logic signed [15:0] level;
    logic block_end_marker;
  } cqd_coef_out_t;
endpackage

// ### hw/cqd_scale_rom.sv
// Purpose: periodic forward and inverse scale tables and quantizer split
// Assumes: quantizer parameter in offset form, 0 to 51
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cqd_consts.svh"
module cqd_scale_rom import cqd_pkg::*; (
  // lookup
  input wire logic [5:0] qp_i,
  input wire logic [3:0] pos_i,
  // scale entries and shift
  output logic [13:0] fwd_o,
  output logic [4:0] inv_o,
  output logic [3:0] qp_div6_o
);
  logic [2:0] qp_mod6;
  logic [1:0] col_sel;
  logic [5:0] qp_div6_full;
  // table row from modulo, shifts from quotient
  assign qp_mod6 = 3'(qp_i % `CQD_QP_PERIOD);
  assign qp_div6_full = 6'(qp_i / `CQD_QP_PERIOD);
  assign qp_div6_o = qp_div6_full[3:0];
  // column: even-even 0, odd-odd 1, mixed 2
  assign col_sel = (!pos_i[2] && !pos_i[0]) ? 2'd0 :
                   (pos_i[2] && pos_i[0]) ? 2'd1 : 2'd2;
  // forward_scale_table and inverse_scale_table
  always_comb begin
    fwd_o = 14'd0;
    inv_o = 5'd0;
    case (qp_mod6)
      3'd0: begin fwd_o = col_sel == 0 ? 14'd13107 : col_sel == 1 ? 14'd5243 : 14'd8066;
        inv_o = col_sel == 0 ? 5'd10 : col_sel == 1 ? 5'd16 : 5'd13; end
      3'd1: begin fwd_o = col_sel == 0 ? 14'd11916 : col_sel == 1 ? 14'd4660 : 14'd7490;
        inv_o = col_sel == 0 ? 5'd11 : col_sel == 1 ? 5'd18 : 5'd14; end
      3'd2: begin fwd_o = col_sel == 0 ? 14'd10082 : col_sel == 1 ? 14'd4194 : 14'd6554;
        inv_o = col_sel == 0 ? 5'd13 : col_sel == 1 ? 5'd20 : 5'd16; end
      3'd3: begin fwd_o = col_sel == 0 ? 14'd9362 : col_sel == 1 ? 14'd3647 : 14'd5825;
        inv_o = col_sel == 0 ? 5'd14 : col_sel == 1 ? 5'd23 : 5'd18; end
      3'd4: begin fwd_o = col_sel == 0 ? 14'd8192 : col_sel == 1 ? 14'd3355 : 14'd5243;
        inv_o = col_sel == 0 ? 5'd16 : col_sel == 1 ? 5'd25 : 5'd20; end
      3'd5: begin fwd_o = col_sel == 0 ? 14'd7282 : col_sel == 1 ? 14'd2893 : 14'd4559;
        inv_o = col_sel == 0 ? 5'd18 : col_sel == 1 ? 5'd29 : 5'd23; end
      default: begin fwd_o = 14'd0; inv_o = 5'd0; end
    endcase
  end
endmodule
`default_nettype wire

// ### hw/cqd_event_coder.sv
// Purpose: turns quantized levels in scan order into run/level events
// Assumes: one level per take pulse, last marks the final scan position
// Notes: the block end marker rides on the event of the final position
`timescale 1ns/1ps
`default_nettype none
`include "cqd_consts.svh"
module cqd_event_coder import cqd_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // level stream
  input wire logic take_i,
  input wire logic is_quant_i,
  input wire logic chroma_ac_i,
  input wire logic last_i,
  input wire logic signed [15:0] level_i,
  // event fields
  output logic ev_level_o,
  output logic [3:0] run_o,
  output logic signed [15:0] level_o,
  output logic eob_o
);
  logic [3:0] run_cnt;
  logic nonzero;
  logic run_full;
  logic [3:0] next_run;
  assign nonzero = level_i != 16'sh0000;
  // chroma ac has 15 coefficients, so its run tops out at 14
  assign run_full = chroma_ac_i ? (run_cnt == `CQD_CHROMA_AC_RUN_MAX) : (run_cnt == 4'hF);
  assign next_run = (nonzero || last_i) ? 4'h0 : (run_full ? run_cnt : run_cnt + 4'h1);
  // zeros since the last nonzero, then the nonzero level; end marker on the event of last
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_cnt <= 4'h0;
      ev_level_o <= 1'b0;
      run_o <= 4'h0;
      level_o <= 16'sh0000;
      eob_o <= 1'b0;
    end else if (take_i) begin
      run_cnt <= is_quant_i ? next_run : run_cnt;
      ev_level_o <= is_quant_i && nonzero;
      run_o <= run_cnt;
      level_o <= is_quant_i ? level_i : 16'sh0000;
      eob_o <= is_quant_i && last_i;
    end
  end
endmodule
`default_nettype wire

// ### hw/cqd_top.sv
// Purpose: quantize and dequantize transform coefficients of one block stream
// Assumes: inputs synchronous to clk_i, offset quantizer parameter 0..51
// Notes: accepts a pass-through coefficient at most every second cycle, dc array levels every cycle
`timescale 1ns/1ps
`default_nettype none
`include "cqd_consts.svh"
module cqd_top import cqd_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // coefficient input
  input wire logic in_valid_i,
  input wire cqd_coef_in_t in_i,
  output logic in_ready_o,
  // coefficient and event output
  output logic out_valid_o,
  input wire logic out_ready_i,
  output cqd_coef_out_t out_o
);
  // timing of one pass-through coefficient:
  //   edge 0: take, result and event computed from the inputs
  //   edge 0 too: out_valid_o rises, in_ready_o goes low
  //   later: ready rises on the edge where the sink takes it
  // so at most one take every second cycle; a flopped ready
  // was worth more than full rate here
  //
  // timing of a dc array:
  //   the levels are stored, nothing is answered per level
  //   after the last one, n cycles sum the n terms of an
  //   output, one more cycle emits it, then the next output
  //   starts; n is 4 for chroma, 16 for luma
  //
  // limitation: a dc array must be complete before its last
  // level; positions never written keep stale contents

  // states of the dc engine:
  //   ST_PASS: one coefficient at a time straight through
  //   ST_DC_SUM: add one stored level per cycle into acc
  //   ST_DC_EMIT: wait for a free slot, then hand out the value
  typedef enum logic [1:0] {ST_PASS, ST_DC_SUM, ST_DC_EMIT} cqd_state_t;

  // registers of the dc engine:
  //   out_n  index of the output being built
  //   term   index of the stored level being added
  //   acc    running signed sum of the current output
  //   dc_luma, dc_qp  kind and parameter of the array

  cqd_state_t state;
  cqd_state_t next_state;
  logic signed [15:0] dc_mem [0:15];
  logic [3:0] out_n;
  logic [3:0] term;
  logic signed [19:0] acc;
  logic dc_luma;
  logic [5:0] dc_qp;
  logic signed [15:0] out_data;
  logic [3:0] out_pos;
  logic out_last;
  logic next_out_valid;

  // handshake decode
  logic accept;
  logic slot_free;
  logic is_quant;
  logic is_dc_in;
  assign accept = in_valid_i && in_ready_o;
  assign slot_free = !out_valid_o || out_ready_i;
  assign is_quant = in_i.op == CQD_OP_QUANT;
  assign is_dc_in = in_i.op == CQD_OP_DC_DEQUANT;
  // slot_free: the output register is empty or is being taken now

  // shared strobes, named once; next state and dc sequencing decode state and accept themselves
  logic dc_take;
  logic dc_emit_go;
  logic in_pass;
  assign in_pass = state == ST_PASS;
  assign dc_take = accept && is_dc_in;
  // an emit only moves with a free slot, so nothing is overwritten
  assign dc_emit_go = (state == ST_DC_EMIT) && slot_free;

  // table lookup: dc arrays always use position zero entries
  logic [5:0] rom_qp;
  logic [3:0] rom_pos;
  logic [13:0] fwd;
  logic [4:0] inv;
  logic [3:0] qp6;
  logic [5:0] qp_in;
  assign qp_in = (in_i.quantizer_parameter > `CQD_QP_MAX) ? `CQD_QP_MAX
                 : in_i.quantizer_parameter;
  assign rom_qp = in_pass ? qp_in : dc_qp;
  assign rom_pos = (state != ST_PASS || in_i.blk != CQD_BLK_AC4) ? `CQD_POS_DC : in_i.pos;

  cqd_scale_rom u_rom (
    .qp_i(rom_qp),
    .pos_i(rom_pos),
    .fwd_o(fwd),
    .inv_o(inv),
    .qp_div6_o(qp6)
  );

  // sign and magnitude of the incoming coefficient
  // the most negative coefficient has no 16-bit magnitude, hence 17 bits
  logic coef_neg;
  logic [16:0] coef_mag;
  assign coef_neg = in_i.data[15];
  assign coef_mag = coef_neg ? 17'(-{in_i.data[15], in_i.data}) : 17'({1'b0, in_i.data});

  // clamp a magnitude and give it back its sign
  function automatic logic signed [15:0] sign_sat(input logic neg, input logic [31:0] mag);
    logic [15:0] m;
    m = (mag > `CQD_LEVEL_MAX) ? 16'h7FFF : mag[15:0];
    sign_sat = neg ? -$signed(m) : $signed(m);
  endfunction

  // forward quantization, 32-bit intermediate
  // range: a 17-bit magnitude times a 14-bit entry stays below 2^31,
  // and the offset is at most 2^22, so the sum never wraps
  logic [31:0] q_prod;
  logic [31:0] f_mag;
  logic [31:0] f_use;
  logic [4:0] q_shift;
  logic [31:0] q_mag;
  logic signed [15:0] q_res;
  assign q_prod = 32'(coef_mag) * 32'(fwd);
  // largest offset is half of 2^(14+q6); rnd_shift trims it toward zero
  assign f_mag = (32'h0000_0001 << (`CQD_ROUND_EXP + 32'(qp6))) >> in_i.rnd_shift;
  assign f_use = (in_i.blk == CQD_BLK_CHROMA_DC) ? (f_mag << 1) : f_mag;
  assign q_shift = (in_i.blk == CQD_BLK_AC4) ? 5'(`CQD_SHIFT_AC + 32'(qp6))
                   : 5'(`CQD_SHIFT_DC + 32'(qp6));
  assign q_mag = (q_prod + f_use) >> q_shift;
  assign q_res = sign_sat(coef_neg, q_mag);

  // ac dequantization
  logic [31:0] d_mag;
  logic signed [15:0] d_res;
  assign d_mag = (32'(coef_mag) * 32'(inv)) << qp6;
  assign d_res = sign_sat(coef_neg, d_mag);

  // normalization of inverse transform samples, rounds half up
  // floor shift: an exact half always goes toward plus infinity
  logic signed [16:0] n_sum;
  logic signed [15:0] n_res;
  assign n_sum = 17'($signed(in_i.data)) + $signed(`CQD_NORM_ADD);
  assign n_res = 16'(n_sum >>> `CQD_NORM_SHIFT);

  // sign of one term of the dc inverse transform
  function automatic logic hneg(input logic [1:0] r, input logic [1:0] c);
    case (r)
      2'd0: hneg = 1'b0;
      2'd1: hneg = c[1];
      2'd2: hneg = c[0] ^ c[1];
      default: hneg = c[0];
    endcase
  endfunction

  // dc inverse transform term: luma 4x4 Hadamard, chroma 2x2 sum/difference
  // one term per cycle: a single adder serves both array sizes,
  // traded against 17 cycles per luma output
  // worst luma sum is 16 * 2^15, within the 20-bit accumulator
  logic term_neg;
  logic [3:0] dc_last_idx;
  logic signed [19:0] term_val;
  logic signed [19:0] next_acc;
  assign term_neg = dc_luma ? (hneg(out_n[3:2], term[3:2]) ^ hneg(term[1:0], out_n[1:0]))
                    : ((out_n[0] & term[0]) ^ (out_n[1] & term[1]));
  assign dc_last_idx = dc_luma ? `CQD_LUMA_DC_LAST : `CQD_CHROMA_DC_LAST;
  assign term_val = 20'(dc_mem[term]);
  assign next_acc = term_neg ? acc - term_val : acc + term_val;

  // dc dequantization after the transform: times R00, then 2^(exp-q6)
  logic acc_neg;
  logic [19:0] acc_mag;
  logic [31:0] x_prod;
  logic [3:0] dc_exp;
  logic [31:0] x_mag;
  logic signed [15:0] x_res;
  assign acc_neg = acc[19];
  assign acc_mag = acc_neg ? -acc : acc;
  assign x_prod = 32'(acc_mag) * 32'(inv);
  assign dc_exp = dc_luma ? 4'(`CQD_EXP_LUMA_DC) : 4'(`CQD_EXP_CHROMA_DC);
  // a negative exponent turns the division into a left shift
  // the shift never exceeds 8, so the product keeps 32 bits
  assign x_mag = (qp6 <= dc_exp) ? (x_prod >> (dc_exp - qp6))
                 : (x_prod << (qp6 - dc_exp));
  assign x_res = sign_sat(acc_neg, x_mag);

  // result selection for pass-through operations
  logic signed [15:0] pass_res;
  logic pass_out;
  assign pass_res = is_quant ? q_res : (in_i.op == CQD_OP_DEQUANT) ? d_res : n_res;
  assign pass_out = accept && !is_dc_in;

  // event coder sees every accepted non-dc coefficient
  // it registers its own fields beside out_data, so all
  // fields of one result change on the same edge
  logic ev_level;
  logic [3:0] ev_run;
  logic signed [15:0] ev_lvl;
  logic ev_eob;
  cqd_event_coder u_ev (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .take_i(pass_out || dc_emit_go),
    .is_quant_i(pass_out && is_quant),
    .chroma_ac_i(in_i.chroma_ac),
    .last_i(in_i.last),
    .level_i(q_res),
    .ev_level_o(ev_level),
    .run_o(ev_run),
    .level_o(ev_lvl),
    .eob_o(ev_eob)
  );

  // next state: collect dc array, accumulate each output, emit it
  always_comb begin
    next_state = state;
    case (state)
      ST_PASS: begin
        if (accept && is_dc_in && in_i.last) begin
          next_state = ST_DC_SUM;
        end
      end
      ST_DC_SUM: begin
        if (term == dc_last_idx) begin
          next_state = ST_DC_EMIT;
        end
      end
      ST_DC_EMIT: begin
        if (slot_free) begin
          next_state = (out_n == dc_last_idx) ? ST_PASS : ST_DC_SUM;
        end
      end
      default: next_state = ST_PASS;
    endcase
  end

  // output valid holds until taken
  assign next_out_valid = pass_out || dc_emit_go || (out_valid_o && !out_ready_i);

  // state, handshake and control flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_PASS;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      state <= next_state;
      // ready only with an empty output slot: trades throughput for a flopped ready
      in_ready_o <= (next_state == ST_PASS) && !next_out_valid;
      out_valid_o <= next_out_valid;
    end
  end

  // dc array memory: levels written by position, chroma as well as luma
  // one write strobe per entry, so a level can only land on its own slot
  for (genvar e = 0; e < 16; e++) begin : g_dc_mem
    logic hit;
    assign hit = dc_take && (in_i.pos == 4'(e));
    always_ff @(posedge clk_i) begin
      if (hit) begin
        dc_mem[e] <= in_i.data;
      end
    end
  end

  // dc sequencing registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_n <= 4'h0;
      term <= 4'h0;
      acc <= 20'sh0_0000;
      dc_luma <= 1'b0;
      dc_qp <= 6'h00;
    end else if (state == ST_PASS) begin
      out_n <= 4'h0;
      term <= 4'h0;
      acc <= 20'sh0_0000;
      if (accept && is_dc_in) begin
        dc_luma <= in_i.blk == CQD_BLK_LUMA_DC;
        dc_qp <= qp_in;
      end
    end else if (state == ST_DC_SUM) begin
      acc <= next_acc;
      term <= term + 4'h1;
    end else if (slot_free) begin
      out_n <= out_n + 4'h1;
      term <= 4'h0;
      acc <= 20'sh0_0000;
    end
  end

  // output data registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_data <= 16'sh0000;
      out_pos <= 4'h0;
      out_last <= 1'b0;
    end else if (pass_out) begin
      out_data <= pass_res;
      out_pos <= in_i.pos;
      out_last <= in_i.last;
    end else if (dc_emit_go) begin
      out_data <= x_res;
      out_pos <= out_n;
      out_last <= out_n == dc_last_idx;
    end
  end

  // output bundle, every field from a flop
  assign out_o = '{data: out_data, pos: out_pos, last: out_last, ev_level: ev_level,
                   run: ev_run, level: ev_lvl, block_end_marker: ev_eob};
endmodule
`default_nettype wire

// ### verif/cqd_sink_model.sv
// Purpose: downstream stage model that paces results out of the datapath
// Assumes: one clock, asynchronous active-low reset
// Notes: a slow sink takes one result in four cycles
`timescale 1ns/1ps
`default_nettype none
module cqd_sink_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // pacing and handshake
  input wire logic stall_i,
  output logic ready_o
);
  logic [1:0] tick;

  // ready only ever changes just after an edge, so a standing result is never torn
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      tick <= tick + 2'h1;
      ready_o <= !stall_i || tick == 2'h3;
    end
  end
endmodule
`default_nettype wire

// ### verif/cqd_top_monitor.sv
// Purpose: port-level checks of the coefficient datapath
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to cqd_top below the module
`timescale 1ns/1ps
`default_nettype none
module cqd_top_monitor import cqd_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // coefficient input
  input wire logic in_valid_i,
  input wire cqd_coef_in_t in_i,
  input wire logic in_ready_o,
  // result output
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire cqd_coef_out_t out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // decoded take and the expected normalized sample
  wire logic take = in_valid_i && in_ready_o;
  wire logic signed [16:0] norm_sum = 17'($signed(in_i.data)) + 17'sh0_0020;
  wire logic signed [15:0] norm_exp = 16'(norm_sum >>> 6);
  logic chroma_q;

  // block kind of the result in flight; only one can stand at a time
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chroma_q <= 1'b0;
    end else if (take) begin
      chroma_q <= in_i.chroma_ac;
    end
  end

  sequence s_dc_last(b);
    take && in_i.op == CQD_OP_DC_DEQUANT && in_i.blk == b && in_i.last;
  endsequence
  sequence s_first_out;
    out_valid_o && out_o.pos == 4'h0;
  endsequence

  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed while the sink stalled");
  property p_busy;
    out_valid_o |-> !in_ready_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("input accepted while a result stands");
  property p_answer;
    take && in_i.op != CQD_OP_DC_DEQUANT |=> out_valid_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no result one cycle after take");
  property p_norm;
    take && in_i.op == CQD_OP_NORM |=> out_o.data == $past(norm_exp);
  endproperty
  a_norm: assert property (p_norm)
    else $error("normalized sample wrong");
  property p_ev;
    out_valid_o && out_o.ev_level |-> out_o.level != 16'h0000;
  endproperty
  a_ev: assert property (p_ev)
    else $error("level event with zero level");
  property p_run;
    out_valid_o && chroma_q |-> out_o.run <= 4'hE;
  endproperty
  a_run: assert property (p_run)
    else $error("chroma ac run above cap");
  property p_qsign;
    take && in_i.op == CQD_OP_QUANT && in_i.data[15] |=> out_o.data[15] || out_o.data == 16'h0000;
  endproperty
  a_qsign: assert property (p_qsign)
    else $error("negative coefficient gave positive level");
  property p_dsign;
    take && in_i.op == CQD_OP_DEQUANT && in_i.data != 16'h0000
      |=> out_o.data[15] == $past(in_i.data[15]) && out_o.data != 16'h0000;
  endproperty
  a_dsign: assert property (p_dsign)
    else $error("dequantized sign or magnitude lost");
  property p_cdc;
    s_dc_last(CQD_BLK_CHROMA_DC) |-> ##6 s_first_out;
  endproperty
  a_cdc: assert property (p_cdc)
    else $error("chroma dc first output late");
  property p_ldc;
    s_dc_last(CQD_BLK_LUMA_DC) |-> ##18 s_first_out;
  endproperty
  a_ldc: assert property (p_ldc)
    else $error("luma dc first output late");
endmodule

bind cqd_top cqd_top_monitor i_cqd_top_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .in_valid_i(in_valid_i), .in_i(in_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i), .out_o(out_o));
`default_nettype wire

// ### verif/coeff_quant_dequant_tb.sv
// Purpose: self-checking bench of the coefficient datapath
// Assumes: 50 MHz clock, reset held 20 cycles
// Notes: expected values come from the scale tables below
`timescale 1ns/1ps
`default_nettype none
module coeff_quant_dequant_tb;
  import cqd_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic in_valid_i = 1'b0;
  cqd_coef_in_t in_i = '0;
  logic in_ready_o;
  logic out_valid_o;
  logic out_ready_i;
  cqd_coef_out_t out_o;
  logic stall = 1'b0;
  int err_total = 0;
  int checked = 0;
  cqd_coef_out_t q[$];
  int fq[6][3] = '{'{13107, 5243, 8066}, '{11916, 4660, 7490}, '{10082, 4194, 6554},
                   '{9362, 3647, 5825}, '{8192, 3355, 5243}, '{7282, 2893, 4559}};
  int rq[6][3] = '{'{10, 16, 13}, '{11, 18, 14}, '{13, 20, 16}, '{14, 23, 18},
                   '{16, 25, 20}, '{18, 29, 23}};
  int hm[4][4] = '{'{1, 1, 1, 1}, '{1, 1, -1, -1}, '{1, -1, -1, 1}, '{1, -1, 1, -1}};
  cqd_blk_t bk[2] = '{CQD_BLK_LUMA_DC, CQD_BLK_CHROMA_DC};

  always #10 clk_i = ~clk_i;

  cqd_top i_cqd_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .in_valid_i(in_valid_i), .in_i(in_i),
    .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_o(out_o));
  cqd_sink_model i_cqd_sink_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .stall_i(stall),
    .ready_o(out_ready_i));

  // results are collected on the handshake edge, tasks poll on the falling edge
  always @(posedge clk_i) begin
    if (out_valid_o && out_ready_i) q.push_back(out_o);
  end

  // table column: even-even first, odd-odd second, mixed third
  function automatic int col(int p);
    return (!p[2] && !p[0]) ? 0 : (p[2] && p[0]) ? 1 : 2;
  endfunction
  // division on the magnitude keeps both signs symmetric
  function automatic int shr(int x, int s);
    return x < 0 ? -((-x) >> s) : x >> s;
  endfunction
  // k: 0 ordinary block, 1 luma dc, 2 chroma dc (doubled offset)
  function automatic logic [15:0] quant(int qp, int p, int rs, int d, int k);
    int a = (d < 0 ? -d : d) * fq[qp % 6][k == 0 ? col(p) : 0];
    a = a + ((((1 << (13 + qp / 6)) >> rs)) << (k == 2));
    a = a >> ((k == 0 ? 15 : 16) + qp / 6);
    if (a > 32767) a = 32767;
    return 16'(d < 0 ? -a : a);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held from just after an edge until the edge that sees ready high
  task automatic send(cqd_op_t o, cqd_blk_t b, logic ca, int qp, int rs, int p, logic l, int d);
    int n = 0;
    @(posedge clk_i);
    in_valid_i <= 1'b1;
    in_i <= '{op:o, blk:b, chroma_ac:ca, quantizer_parameter:6'(qp), rnd_shift:2'(rs),
              pos:4'(p), last:l, data:16'(d)};
    do begin
      @(negedge clk_i);
      n++;
    end while (in_ready_o !== 1'b1 && n < 200);
    @(posedge clk_i);
    in_valid_i <= 1'b0;
  endtask
  task automatic get(output cqd_coef_out_t r);
    int n = 0;
    while (q.size() == 0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    r = (q.size() != 0) ? q.pop_front() : '0;
  endtask

  task automatic t_quant();
    cqd_coef_out_t r;
    int qp, p, d;
    stall <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      qp = (i == 12) ? 51 : (i * 7) % 52;
      p = (i * 5) % 16;
      d = (i % 2) ? -(1000 + i * 2311) : 1000 + i * 2311;
      send(CQD_OP_QUANT, CQD_BLK_AC4, 1'b0, qp, i % 4, p, 1'b1, d);
      get(r);
      chk(r.data, quant(qp, p, i % 4, d, 0));
    end
    stall <= 1'b0;
    $display("test quant_ac done");
  endtask
  task automatic t_dcq();
    cqd_coef_out_t r;
    int d;
    for (int i = 0; i < 6; i++) begin
      d = (i % 2) ? -20000 : 17000 + i;
      send(CQD_OP_QUANT, bk[i % 2], 1'b0, i * 10, 0, i % 4, 1'b1, d);
      get(r);
      chk(r.data, quant(i * 10, 0, 0, d, 1 + i % 2));
    end
    $display("test quant_dc done");
  endtask
  task automatic t_deq();
    cqd_coef_out_t r;
    int qp, p, v;
    for (int i = 0; i < 12; i++) begin
      qp = (i * 7) % 52;
      p = (i * 5) % 16;
      v = (i % 2) ? -(1 + i % 4) : 1 + i % 4;
      send(CQD_OP_DEQUANT, CQD_BLK_AC4, 1'b0, qp, 0, p, 1'b0, v);
      get(r);
      chk(r.data, 16'((v * rq[qp % 6][col(p)]) << (qp / 6)));
    end
    $display("test dequant_ac done");
  endtask
  task automatic t_norm();
    cqd_coef_out_t r;
    int nv[7] = '{-32768, 32767, -33, 31, 32, -32, 100};
    for (int i = 0; i < 7; i++) begin
      send(CQD_OP_NORM, CQD_BLK_AC4, 1'b0, 0, 0, 0, 1'b0, nv[i]);
      get(r);
      chk(r.data, 16'((nv[i] + 32) >>> 6));
    end
    $display("test norm done");
  endtask
  // chroma dc: transform of the four pair values, then scale by 13 over 2
  task automatic t_cdc();
    cqd_coef_out_t r;
    int lv[4] = '{5, -3, 2, 7};
    int s[4];
    for (int i = 0; i < 4; i++) send(CQD_OP_DC_DEQUANT, CQD_BLK_CHROMA_DC, 1'b0, 14, 0, i,
                                     i == 3, lv[i]);
    s[0] = lv[0] + lv[1] + lv[2] + lv[3];
    s[1] = lv[0] - lv[1] + lv[2] - lv[3];
    s[2] = lv[0] + lv[1] - lv[2] - lv[3];
    s[3] = lv[0] - lv[1] - lv[2] + lv[3];
    for (int k = 0; k < 4; k++) begin
      get(r);
      chk(r.data, 16'(shr(s[k] * rq[2][0], 1)));
      chk(r.pos, 16'(k));
      chk(r.last, 16'(k == 3));
    end
    $display("test chroma_dc done");
  endtask
  task automatic t_ldc();
    cqd_coef_out_t r;
    int x[16];
    int s;
    for (int k = 0; k < 16; k++) begin
      x[k] = (k * 3) % 7 - 3;
      send(CQD_OP_DC_DEQUANT, CQD_BLK_LUMA_DC, 1'b0, 6, 0, k, k == 15, x[k]);
    end
    for (int k = 0; k < 16; k++) begin
      s = 0;
      for (int a = 0; a < 4; a++)
        for (int b = 0; b < 4; b++) s += hm[k / 4][a] * x[a * 4 + b] * hm[b][k % 4];
      get(r);
      chk(r.data, 16'(shr(s * rq[0][0], 3)));
      chk(r.pos, 16'(k));
    end
    $display("test luma_dc done");
  endtask
  // a 15-entry chroma ac block ending on the longest run, then a short block
  task automatic t_ev();
    cqd_coef_out_t r;
    int dv[18] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, -10, 10, 0, 0};
    int run = 0;
    logic l;
    for (int i = 0; i < 18; i++) begin
      l = (i == 14 || i == 17);
      send(CQD_OP_QUANT, CQD_BLK_AC4, 1'(i < 15), 0, 0, 0, l, dv[i]);
      get(r);
      chk(r.ev_level, dv[i] != 0);
      chk(r.block_end_marker, l);
      if (dv[i] != 0) begin
        chk(r.run, 16'(run));
        chk(r.level, quant(0, 0, 0, dv[i], 0));
      end
      run = (dv[i] != 0 || l) ? 0 : run + 1;
    end
    $display("test events done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_quant();
    t_dcq();
    t_deq();
    t_norm();
    t_cdc();
    t_ldc();
    t_ev();
    summarize();
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    #(20 * 10000);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
